// ==== rtl/eiss_pkg.sv ====
// Package of constants and types for the external interrupt sense-select block
package eiss_pkg;
   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   localparam logic [11:0] EISS_OFS_SENSE_HIGH = 12'h000;
   localparam logic [11:0] EISS_OFS_SENSE_LOW = 12'h004;
   localparam logic [11:0] EISS_OFS_STATUS = 12'h008;
   localparam logic [11:0] EISS_OFS_ENABLE = 12'h00C;
   localparam logic [11:0] EISS_OFS_IRQ_MASK = 12'h010;
   localparam logic [11:0] EISS_OFS_EVENT = 12'h014;
   // ==========================================================
   // Widths, reset values and masks
   localparam int EISS_NREQ = 16;
   localparam logic [15:0] EISS_RST16 = 16'h0000;
   // Implemented bits of the high sense register (15:14 and 7:0)
   localparam logic [15:0] EISS_HIGH_WMASK = 16'hC0FF;
   // Requests that exist: 15 and 11..0
   localparam logic [15:0] EISS_REQ_MASK = 16'h8FFF;
   // Slow-timer request index and its idle (reset) setting
   localparam int EISS_TIMER_IDX = 15;
   localparam logic [1:0] EISS_FIELD_ZERO = 2'h0;
   // Event register bits
   localparam int EISS_EVT_FLAG = 0;
   localparam int EISS_EVT_BADWR = 1;
   localparam logic [1:0] EISS_EVT_MASK = 2'h3;
   // ==========================================================
   // Sense modes, two bits: rise bit above fall bit
   typedef enum logic [1:0] {
      EISS_LOW = 2'b00,
      EISS_FALL = 2'b01,
      EISS_RISE = 2'b10,
      EISS_BOTH = 2'b11
   } eiss_mode_t;
   // APB request carrier
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } eiss_apb_req_t;
endpackage

// ==== rtl/eiss_sync.sv ====
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module eiss_sync import eiss_pkg::*; #(
   parameter int WIDTH = EISS_NREQ,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   // First stage, read only by the second stage
   logic [WIDTH-1:0] meta_q;
   // ==========================================================
   // Synchroniser chain
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= RESET_VAL;
         synced <= RESET_VAL;
      end else if (ce) begin
         meta_q <= async;
         synced <= meta_q;
      end
   end
endmodule // eiss_sync

// ==== rtl/eiss_detect.sv ====
// Per-input sense detector: level, falling, rising or both edges
`timescale 1ns/1ns
module eiss_detect import eiss_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic sample,
   input wire logic [1:0] mode,
   output logic hit
);
   // Previous sample; reset high so a high input is not seen as a rising edge
   logic prev_q;
   logic fell;
   logic rose;
   // ==========================================================
   // Edge history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= 1'b1;
      end else if (ce) begin
         prev_q <= sample;
      end
   end
   assign fell = prev_q & ~sample;
   assign rose = ~prev_q & sample;
   // ==========================================================
   // Mode decode
   always_comb begin
      unique case (eiss_mode_t'(mode))
         EISS_LOW: hit = ~sample;
         EISS_FALL: hit = fell;
         EISS_RISE: hit = rose;
         EISS_BOTH: hit = fell | rose;
      endcase
   end
endmodule // eiss_detect

// ==== rtl/eiss_top.sv ====
// Top of the external interrupt sense-select block with APB registers
// ==========================================================
`timescale 1ns/1ns
module eiss_top import eiss_pkg::*; #(
   parameter int NREQ = EISS_NREQ
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [11:0] extRequestPins,
   input wire logic slowTimerOverflowInt,
   output logic cpuRequest,
   output logic irq
);
   // ==========================================================
   // Declarations
   eiss_apb_req_t req; // Bundled APB request
   logic [15:0] senseHigh_q; // High sense register
   logic [15:0] senseLow_q; // Low sense register
   logic [15:0] status_q; // Request status flags
   logic [15:0] enable_q; // Request enables
   logic [1:0] evt_q; // Sticky block events
   logic [1:0] evtMask_q; // Event interrupt mask
   logic [NREQ-1:0] rawIn; // Raw request inputs
   logic [NREQ-1:0] syncIn; // Synchronised inputs
   logic [NREQ-1:0] hit; // Detected conditions
   logic [31:0] senseAll; // Both sense registers joined
   logic [15:0] hitMasked; // Hits on requests that exist
   logic wrHit; // Write access phase
   logic rdHit; // Read access phase
   logic mapped; // Address decodes to a register
   logic [15:0] wdata16; // Low half of write data
   logic badHighWr; // Write breaks reserved or prohibited bits
   logic [1:0] timerField; // Written request 15 field

   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign wrHit = req.sel & req.enable & req.write & pready;
   assign rdHit = req.sel & req.enable & ~req.write;
   assign wdata16 = req.wdata[15:0];
   assign timerField = wdata16[15:14];

   // Address decode, used for the error answer only
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == EISS_OFS_SENSE_HIGH) || (a == EISS_OFS_SENSE_LOW) ||
         (a == EISS_OFS_STATUS) || (a == EISS_OFS_ENABLE) ||
         (a == EISS_OFS_IRQ_MASK) || (a == EISS_OFS_EVENT);
   endfunction
   assign mapped = is_mapped(req.addr);

   // ==========================================================
   // Input gathering: pins for 11..0, slow timer for 15
   always_comb begin
      rawIn = '1; // Missing requests idle high
      rawIn[11:0] = extRequestPins;
      // Timer overflow pulse is active high; invert so a pulse is a falling edge
      rawIn[EISS_TIMER_IDX] = ~slowTimerOverflowInt;
   end

   eiss_sync #(
      .WIDTH(NREQ),
      .RESET_VAL('1)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .async(rawIn),
      .synced(syncIn)
   );

   // Join the two registers so request n owns bits 2n+1:2n
   assign senseAll = {senseHigh_q, senseLow_q};

   // ==========================================================
   // One detector per request
   genvar gi;
   generate
      for (gi = 0; gi < NREQ; gi++) begin : g_det
         eiss_detect u_det (
            .clk(clk),
            .nrst(nrst),
            .ce(ce),
            .sample(syncIn[gi]),
            .mode(senseAll[2*gi+1 -: 2]),
            .hit(hit[gi])
         );
      end
   endgenerate

   // Request 15 idles at 00 and senses only at 01, so mask its level mode
   always_comb begin
      hitMasked = hit[15:0] & EISS_REQ_MASK;
      if (senseHigh_q[15:14] == EISS_FIELD_ZERO) begin
         hitMasked[EISS_TIMER_IDX] = 1'b0;
      end
   end

   // ==========================================================
   // Write check: reserved bits must be zero, request 15 only 00 or 01
   always_comb begin
      badHighWr = 1'b0;
      if (wrHit && req.addr == EISS_OFS_SENSE_HIGH) begin
         badHighWr = |(wdata16 & ~EISS_HIGH_WMASK);
         if (timerField == EISS_RISE || timerField == EISS_BOTH) begin
            badHighWr = 1'b1;
         end
      end
   end

   // ==========================================================
   // High sense register; prohibited request 15 codes are refused
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         senseHigh_q <= EISS_RST16;
      end else if (ce && wrHit && req.addr == EISS_OFS_SENSE_HIGH) begin
         senseHigh_q[7:0] <= wdata16[7:0];
         if (timerField == EISS_LOW || timerField == EISS_FALL) begin
            senseHigh_q[15:14] <= timerField;
         end
         senseHigh_q[13:8] <= '0;
      end
   end

   // Low sense register, every field resets to level sensing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         senseLow_q <= EISS_RST16;
      end else if (ce && wrHit && req.addr == EISS_OFS_SENSE_LOW) begin
         senseLow_q <= wdata16;
      end
   end

   // ==========================================================
   // Status flags: a hit sets, writing zero to a flag clears;
   // a hit in the same cycle as the clear wins so no request is lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= EISS_RST16;
      end else if (ce) begin
         if (wrHit && req.addr == EISS_OFS_STATUS) begin
            status_q <= ((status_q & wdata16) | hitMasked) & EISS_REQ_MASK;
         end else begin
            status_q <= (status_q | hitMasked) & EISS_REQ_MASK;
         end
      end
   end

   // Enable register: one bit per existing request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         enable_q <= EISS_RST16;
      end else if (ce && wrHit && req.addr == EISS_OFS_ENABLE) begin
         enable_q <= wdata16 & EISS_REQ_MASK;
      end
   end

   // Forward only enabled flags; software should disable before
   // retuning a sense field, since a change may raise a false flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cpuRequest <= 1'b0;
      end else if (ce) begin
         cpuRequest <= |(status_q & enable_q);
      end
   end

   // ==========================================================
   // Block events: any new flag, bad high sense write (reserved bits or refused request 15 code); write 1 clears
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         evt_q <= '0;
      end else if (ce) begin
         logic [1:0] setEvt;
         logic [1:0] clrEvt;
         setEvt = '0;
         setEvt[EISS_EVT_FLAG] = |(hitMasked & ~status_q);
         setEvt[EISS_EVT_BADWR] = badHighWr;
         clrEvt = '0;
         if (wrHit && req.addr == EISS_OFS_EVENT) begin
            clrEvt = req.wdata[1:0];
         end
         // Set wins over clear
         evt_q <= (evt_q & ~clrEvt) | setEvt;
      end
   end

   // Event mask, same layout
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         evtMask_q <= '0;
      end else if (ce && wrHit && req.addr == EISS_OFS_IRQ_MASK) begin
         evtMask_q <= req.wdata[1:0] & EISS_EVT_MASK;
      end
   end

   // Level interrupt from any unmasked sticky event
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(evt_q & evtMask_q);
      end
   end

   // ==========================================================
   // APB answer: one wait state, pready registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
      end else if (ce) begin
         // High during the second access cycle only
         pready <= req.sel & req.enable & ~pready;
      end
   end

   // Unmapped addresses answer with an error
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pslverr <= 1'b0;
      end else if (ce) begin
         pslverr <= req.sel & req.enable & ~pready & ~mapped;
      end
   end

   // Read data registered with pready; reserved bits read zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= '0;
      end else if (ce) begin
         prdata <= '0;
         if (rdHit && !pready) begin
            unique case (req.addr)
               EISS_OFS_SENSE_HIGH: prdata <= {16'h0000, senseHigh_q & EISS_HIGH_WMASK};
               EISS_OFS_SENSE_LOW: prdata <= {16'h0000, senseLow_q};
               EISS_OFS_STATUS: prdata <= {16'h0000, status_q};
               EISS_OFS_ENABLE: prdata <= {16'h0000, enable_q};
               EISS_OFS_IRQ_MASK: prdata <= {30'h00000000, evtMask_q};
               EISS_OFS_EVENT: prdata <= {30'h00000000, evt_q};
               default: prdata <= '0;
            endcase
         end
      end
   end
endmodule // eiss_top

// ==== bench/eiss_monitor.sv ====
// Port-level assertion checker for the sense-select block
`timescale 1ns/1ns
module eiss_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // Bus phases
   sequence apbSetup;
      psel && !penable;
   endsequence
   sequence apbAccess;
      psel && penable;
   endsequence
   // Exactly one wait state, then a single-cycle answer
   apb_wait_state_a: assert property (apbSetup ##1 apbAccess |=> pready)
      else $error("answer not one cycle after access");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("answer held too long");
   answer_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("answer without access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   err_cause_a: assert property (pslverr |-> pready)
      else $error("error without answer");
   // ==========================================================
   // Address decode and register contents
   unmapped_err_a: assert property (pready && paddr > 12'h014 |-> pslverr)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   reserved_zero_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[13:8] == 6'h0)
      else $error("reserved sense bits not zero");
   timer_field_a: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[15])
      else $error("illegal timer sense setting");
endmodule // eiss_monitor
bind eiss_top eiss_monitor u_eiss_monitor (.*);

// ==== bench/eiss_pins.sv ====
// Model of the request pins and the slow-timer overflow source
`timescale 1ns/1ns
module eiss_pins (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [11:0] lvl,
   input wire logic tmr,
   output logic [11:0] pins,
   output logic timerInt
);
   // Pins rest high on their pull-ups while reset holds the board
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pins <= 12'hFFF;
      end else begin
         pins <= lvl;
      end
   end
   // Overflow comes from the on-chip timer, never from a pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timerInt <= 1'b0;
      end else begin
         timerInt <= tmr;
      end
   end
endmodule // eiss_pins

// ==== bench/tb_eiss_top.sv ====
// Self-checking testbench for the sense-select block
`timescale 1ns/1ns
module tb_eiss_top import eiss_pkg::*;;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, cpuRequest, irq, tmr, timerInt, ce;
   logic [11:0] paddr, lvl, pins, ra;
   logic [31:0] pwdata, prdata;
   logic [33:0] notes[$]; // Expected answers: read flag, error, data
   logic [33:0] n;
   logic [15:0] d;
   int checked, failures, sh;
   // Free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   eiss_pins u_eiss_pins (.clk(clk), .nrst(nrst), .lvl(lvl), .tmr(tmr), .pins(pins),
      .timerInt(timerInt));
   eiss_top u_eiss_top (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extRequestPins(pins), .slowTimerOverflowInt(timerInt),
      .cpuRequest(cpuRequest), .irq(irq));
   // ==========================================================
   // Compare, bus master and pin helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   // Request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] dat,
      input logic err);
      notes.push_back({!w, err, 16'h0, dat});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, dat};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Margin above the three-edge pin-to-flag path
   task automatic pinStep(input int p, input logic v, input logic f);
      // Whole-vector update keeps the automatic index out of the assignment target
      lvl <= (lvl & ~(12'h001 << p)) | (12'(v) << p);
      repeat (6) @(posedge clk);
      check({31'h0, cpuRequest}, {31'h0, f});
      apb(1'b0, 12'h008, 16'(f) << p, 1'b0);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic results;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Answer watcher: oldest note against each answer
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         n = notes.pop_front();
         check({31'h0, pslverr}, {31'h0, n[32]});
         if (n[33]) check(prdata, n[31:0]);
      end
   end
   // Hang guard, well beyond the expected run
   initial begin
      #2000000;
      failures++;
      results;
   end
   // ==========================================================
   // Main sequence
   initial begin
      d = 16'($urandom(67672));
      {nrst, psel, penable, pwrite, paddr, pwdata, tmr} = '0;
      lvl = 12'hFFF;
      ce = 1'b1;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) apb(1'b0, 12'(4 * i), 16'h0, 1'b0);
      tmr <= 1'b1;
      repeat (6) @(posedge clk);
      tmr <= 1'b0;
      apb(1'b0, 12'h008, 16'h0, 1'b0);
      done("reset");
      apb(1'b0, 12'h018, 16'h0, 1'b1);
      apb(1'b1, 12'h018, 16'hFFFF, 1'b1);
      done("unmapped");
      d = {2'b01, 6'h01 | 6'($urandom), 8'($urandom)};
      apb(1'b1, 12'h000, d, 1'b0);
      apb(1'b0, 12'h000, {2'b01, 6'h0, d[7:0]}, 1'b0);
      apb(1'b0, 12'h014, 16'h2, 1'b0);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h010, 16'h2, 1'b0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h014, 16'h2, 1'b0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      done("reserved and irq");
      apb(1'b1, 12'h008, 16'h0, 1'b0);
      tmr <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b0, 12'h008, 16'h8000, 1'b0);
      apb(1'b1, 12'h008, 16'h0, 1'b0);
      tmr <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, 12'h008, 16'h0, 1'b0);
      done("timer");
      // Prohibited request 15 code is refused and flagged as a bad write
      apb(1'b1, 12'h000, {2'b11, 6'h0, d[7:0]}, 1'b0);
      apb(1'b0, 12'h000, {2'b01, 6'h0, d[7:0]}, 1'b0);
      apb(1'b0, 12'h014, 16'h3, 1'b0);
      apb(1'b1, 12'h014, 16'h3, 1'b0);
      done("refused timer code");
      for (int p = 5; p < 12; p++) begin
         for (int m = 0; m < 4; m++) begin
            sh = (p < 8) ? 2 * p : 2 * (p - 8);
            ra = (p < 8) ? 12'h004 : 12'h000;
            apb(1'b1, 12'h00C, 16'h0, 1'b0);
            apb(1'b1, ra, 16'(m << sh), 1'b0);
            apb(1'b0, ra, 16'(m << sh), 1'b0);
            apb(1'b1, 12'h008, 16'h0, 1'b0);
            apb(1'b1, 12'h00C, 16'(1 << p), 1'b0);
            pinStep(p, 1'b0, m != 2);
            apb(1'b1, 12'h008, 16'h0, 1'b0);
            pinStep(p, 1'b1, m != 1);
            apb(1'b1, 12'h008, 16'h0, 1'b0);
         end
      end
      done("modes");
      // One running edge first so the cleared flag reaches cpuRequest before the freeze
      @(posedge clk);
      ce <= 1'b0;
      lvl <= 12'h7FF;
      repeat (6) @(posedge clk);
      check({31'h0, cpuRequest}, 32'h0);
      ce <= 1'b1;
      repeat (6) @(posedge clk);
      check({31'h0, cpuRequest}, 32'h1);
      apb(1'b0, 12'h008, 16'h0800, 1'b0);
      done("clock enable");
      results;
   end
endmodule // tb_eiss_top
